// file: rtc_defines.vh
// constants for the rotate-through-carry unit: offsets, fields, resets, codes
`ifndef RTC_DEFINES_VH
`define RTC_DEFINES_VH

// register byte offsets on the apb bus
`define RTC_OFS_CTRL 8'h00
`define RTC_OFS_WORD_LO 8'h04
`define RTC_OFS_WORD_HI 8'h08
`define RTC_OFS_SCAN 8'h0C
`define RTC_OFS_FLAGS 8'h10
`define RTC_OFS_CARRY_OP 8'h14
`define RTC_OFS_STATUS 8'h18

// control register fields
`define RTC_CTRL_OP_LSB 0
`define RTC_CTRL_OP_MSB 1
`define RTC_CTRL_EDGE_BIT 2

// scan register field: execution condition of this scan
`define RTC_SCAN_COND_BIT 0

// flag register fields
`define RTC_FLAG_ERROR_BIT 0
`define RTC_FLAG_EQUALS_BIT 1
`define RTC_FLAG_CARRY_BIT 2
`define RTC_FLAG_NEGATIVE_BIT 3

// carry operation register fields
`define RTC_CARRY_SET_BIT 0
`define RTC_CARRY_CLEAR_BIT 1

// status register fields
`define RTC_STAT_PREV_COND_BIT 0
`define RTC_STAT_LAST_RAN_BIT 1
`define RTC_STAT_COUNT_LSB 16
`define RTC_STAT_COUNT_MSB 31

// operation codes
`define RTC_OP_DOUBLE_ROTATE_LEFT_CARRY 2'h0
`define RTC_OP_ROTATE_RIGHT_CARRY 2'h1
`define RTC_OP_DOUBLE_ROTATE_RIGHT_CARRY 2'h2
`define RTC_OP_ROTATE_LEFT_NO_CARRY 2'h3

// reset values
`define RTC_RST_WORD 16'h0000
`define RTC_RST_OP 2'h0
`define RTC_RST_COUNT 16'h0000
`define RTC_RST_DATA 32'h00000000

// apb wait states before pready, counted in clock cycles
`define RTC_APB_WAIT_CYCLES 1

`endif

// file: rtc_rotator.v
// combinational ring rotator and flag evaluation for the four rotate operations
`include "rtc_defines.vh"

module rtc_rotator (
   // request
   input wire [1:0] op,
   input wire [15:0] word_lo,
   input wire [15:0] word_hi,
   input wire carry_in,
   // result
   output reg [15:0] res_lo,
   output reg [15:0] res_hi,
   output reg carry_out,
   output reg error_out,
   output reg equals_out,
   output reg negative_out
);

   // ring moves and flags; double forms look at both words
   always @* begin
      res_lo = word_lo;
      res_hi = word_hi;
      carry_out = carry_in;
      error_out = 1'b0;
      equals_out = 1'b0;
      negative_out = 1'b0;
      case (op)
         `RTC_OP_DOUBLE_ROTATE_LEFT_CARRY: begin
            // 33-bit ring {carry, hi, lo} one step toward msb
            res_hi = {word_hi[14:0], word_lo[15]};
            res_lo = {word_lo[14:0], carry_in};
            carry_out = word_hi[15];
         end
         `RTC_OP_ROTATE_RIGHT_CARRY: begin
            // 17-bit ring {carry, lo} one step toward lsb
            res_lo = {carry_in, word_lo[15:1]};
            carry_out = word_lo[0];
         end
         `RTC_OP_DOUBLE_ROTATE_RIGHT_CARRY: begin
            res_hi = {carry_in, word_hi[15:1]};
            res_lo = {word_hi[0], word_lo[15:1]};
            carry_out = word_lo[0];
         end
         `RTC_OP_ROTATE_LEFT_NO_CARRY: begin
            // old carry is thrown away here
            res_lo = {word_lo[14:0], word_lo[15]};
            carry_out = word_lo[15];
         end
         default: begin
            carry_out = carry_in;
         end
      endcase
      if (op == `RTC_OP_ROTATE_RIGHT_CARRY || op == `RTC_OP_ROTATE_LEFT_NO_CARRY) begin
         equals_out = (res_lo == 16'h0000);
         negative_out = res_lo[15];
      end else begin
         equals_out = (res_lo == 16'h0000) && (res_hi == 16'h0000);
         negative_out = res_hi[15];
      end
   end

endmodule

// file: rtc_unit.v
// rotate-through-carry execution unit with apb register access
// register map: byte offsets, one 32-bit word each, unused bits read zero
// 0x00 control, read/write
//    [1:0] operation select
//          0 double rotate left through carry
//          1 rotate right through carry
//          2 double rotate right through carry
//          3 rotate left without carry
//    [2] edge variant: run once on a false-to-true condition
// 0x04 low operand word, read/write, [15:0]
// 0x08 high operand word, read/write, [15:0]
// 0x0C scan, write only, reads zero
//    [0] execution condition of this scan
// 0x10 flags, read only
//    [0] error [1] equals [2] carry [3] negative
// 0x14 carry operation, write only, reads zero
//    [0] set carry, [1] clear carry, both: set wins
// 0x18 status, read only
//    [0] condition of the last scan
//    [1] last scan carried out a rotate
//    [31:16] rotate count, wraps
// a write to a read-only or unmapped offset answers with a slave error
// and changes nothing; an unmapped read returns zero
//
// bus timing
// setup cycle, access cycle with ready low, access cycle with ready high
// every transfer takes exactly one wait state, whatever its offset
// a write lands at the edge that ends the ready-high cycle
// read data stand in the ready-high cycle and the cycle after it, and are zero otherwise
//
// execution timing
// an executing scan replaces both words and all four flags at its commit
// edge, and the done pulse follows in the next cycle
// a refused scan still records its condition for edge detection
// single-word rotates work on the low word and leave the high word alone
//
// limitations
// operand words live here; the sequencer loads them before a scan
// and reads them back afterwards, so addressing stays outside
// no falling-edge variant and no immediate refresh form exist
// the rotate count wraps and only serves to show progress
`include "rtc_defines.vh"

module rtc_unit (
   // clock and reset
   input wire CLK,
   input wire RESET,
   // apb slave
   input wire PSEL,
   input wire PENABLE,
   input wire PWRITE,
   input wire [7:0] PADDR,
   input wire [31:0] PWDATA,
   output reg [31:0] PRDATA,
   output reg PREADY,
   output reg PSLVERR,
   // operand words as seen by the rest of the cpu
   output reg [15:0] OPERAND_WORD_LO,
   output reg [15:0] OPERAND_WORD_HI,
   // condition flags
   output reg ERROR_FLAG,
   output reg EQUALS_FLAG,
   output reg CARRY_FLAG,
   output reg NEGATIVE_FLAG,
   // one-cycle pulse after a rotate was carried out
   output reg EXEC_DONE
);

   // true when the offset names a mapped register
   function is_mapped;
      input [7:0] addr;
      begin
         case (addr)
            `RTC_OFS_CTRL, `RTC_OFS_WORD_LO, `RTC_OFS_WORD_HI, `RTC_OFS_SCAN,
            `RTC_OFS_FLAGS, `RTC_OFS_CARRY_OP, `RTC_OFS_STATUS: is_mapped = 1'b1;
            default: is_mapped = 1'b0;
         endcase
      end
   endfunction

   // true when the offset may be written; flags and status are read-only
   function is_writable;
      input [7:0] addr;
      begin
         case (addr)
            `RTC_OFS_CTRL, `RTC_OFS_WORD_LO, `RTC_OFS_WORD_HI, `RTC_OFS_SCAN,
            `RTC_OFS_CARRY_OP: is_writable = 1'b1;
            default: is_writable = 1'b0;
         endcase
      end
   endfunction

   // control state
   reg [1:0] op_code;
   reg edge_mode;
   reg prev_cond;
   reg last_ran;
   reg [15:0] exec_count;

   // combinational helpers
   wire access_phase;
   wire write_commit;
   wire scan_write;
   wire scan_cond;
   wire run_now;
   wire carry_write;
   wire next_carry_manual;
   wire [15:0] rot_lo;
   wire [15:0] rot_hi;
   wire rot_carry;
   wire rot_error;
   wire rot_equals;
   wire rot_negative;
   reg [31:0] next_prdata;

   // the access phase is held until our registered pready is seen high
   assign access_phase = PSEL && PENABLE;
   // writes act only at the edge that completes the transfer
   assign write_commit = access_phase && PREADY && PWRITE && is_writable(PADDR);
   assign scan_write = write_commit && (PADDR == `RTC_OFS_SCAN);
   assign scan_cond = PWDATA[`RTC_SCAN_COND_BIT];
   // a scan executes on a true condition, edge mode also needs prior false
   assign run_now = scan_write && scan_cond && (!edge_mode || !prev_cond);
   assign carry_write = write_commit && (PADDR == `RTC_OFS_CARRY_OP);
   // set wins if software writes both bits at once
   assign next_carry_manual = PWDATA[`RTC_CARRY_SET_BIT] ? 1'b1 :
                              (PWDATA[`RTC_CARRY_CLEAR_BIT] ? 1'b0 : CARRY_FLAG);

   // ring rotator, fed from the stored carry so set/clear carry takes part
   // op_code only changes between scans, so the result is settled at commit
   rtc_rotator u_rotator (
      .op(op_code),
      .word_lo(OPERAND_WORD_LO),
      .word_hi(OPERAND_WORD_HI),
      .carry_in(CARRY_FLAG),
      .res_lo(rot_lo),
      .res_hi(rot_hi),
      .carry_out(rot_carry),
      .error_out(rot_error),
      .equals_out(rot_equals),
      .negative_out(rot_negative)
   );

   // apb handshake: one wait state, so read data is registered in time
   always @(posedge CLK) begin
      if (RESET) begin
         PREADY <= 1'b0;
         PSLVERR <= 1'b0;
      end else begin
         // registered ready, so it never depends on this cycle's bus lines
         if (access_phase && !PREADY) begin
            PREADY <= 1'b1;
            PSLVERR <= !is_mapped(PADDR) || (PWRITE && !is_writable(PADDR));
         end else begin
            // one beat per transfer: ready drops after a single cycle
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
         end
      end
   end

   // read multiplexer; unmapped offsets read as zero
   always @* begin
      next_prdata = `RTC_RST_DATA;
      case (PADDR)
         `RTC_OFS_CTRL: begin
            next_prdata[`RTC_CTRL_OP_MSB:`RTC_CTRL_OP_LSB] = op_code;
            next_prdata[`RTC_CTRL_EDGE_BIT] = edge_mode;
         end
         `RTC_OFS_WORD_LO: begin
            next_prdata[15:0] = OPERAND_WORD_LO;
         end
         `RTC_OFS_WORD_HI: begin
            next_prdata[15:0] = OPERAND_WORD_HI;
         end
         `RTC_OFS_FLAGS: begin
            next_prdata[`RTC_FLAG_ERROR_BIT] = ERROR_FLAG;
            next_prdata[`RTC_FLAG_EQUALS_BIT] = EQUALS_FLAG;
            next_prdata[`RTC_FLAG_CARRY_BIT] = CARRY_FLAG;
            next_prdata[`RTC_FLAG_NEGATIVE_BIT] = NEGATIVE_FLAG;
         end
         // status packs the edge history and the rotate count
         `RTC_OFS_STATUS: begin
            next_prdata[`RTC_STAT_PREV_COND_BIT] = prev_cond;
            next_prdata[`RTC_STAT_LAST_RAN_BIT] = last_ran;
            next_prdata[`RTC_STAT_COUNT_MSB:`RTC_STAT_COUNT_LSB] = exec_count;
         end
         default: begin
            next_prdata = `RTC_RST_DATA;
         end
      endcase
   end

   // read data captured in the wait cycle and held while pready is high
   always @(posedge CLK) begin
      if (RESET) begin
         PRDATA <= `RTC_RST_DATA;
      end else if (access_phase && !PREADY && !PWRITE) begin
         PRDATA <= next_prdata;
      // cleared outside the answer so stale data never looks valid
      end else if (!access_phase) begin
         PRDATA <= `RTC_RST_DATA;
      end
   end

   // control register: operation select and edge variant
   always @(posedge CLK) begin
      if (RESET) begin
         op_code <= `RTC_RST_OP;
         edge_mode <= 1'b0;
      end else if (write_commit && PADDR == `RTC_OFS_CTRL) begin
         // a new select only acts at the next scan, never mid-rotate
         op_code <= PWDATA[`RTC_CTRL_OP_MSB:`RTC_CTRL_OP_LSB];
         edge_mode <= PWDATA[`RTC_CTRL_EDGE_BIT];
      end
   end

   // condition history: every scan remembers its condition for edge detection
   always @(posedge CLK) begin
      if (RESET) begin
         prev_cond <= 1'b0;
      end else if (scan_write) begin
         // refused scans update it too, or a held condition would rerun
         prev_cond <= scan_cond;
      end
   end

   // operand words: loaded by software or replaced by the rotate result
   always @(posedge CLK) begin
      if (RESET) begin
         OPERAND_WORD_LO <= `RTC_RST_WORD;
         OPERAND_WORD_HI <= `RTC_RST_WORD;
      end else if (run_now) begin
         // both words in the same edge as the flags
         OPERAND_WORD_LO <= rot_lo;
         OPERAND_WORD_HI <= rot_hi;
      end else if (write_commit && PADDR == `RTC_OFS_WORD_LO) begin
         // one transfer at a time, so a rotate never meets a word write
         OPERAND_WORD_LO <= PWDATA[15:0];
      end else if (write_commit && PADDR == `RTC_OFS_WORD_HI) begin
         OPERAND_WORD_HI <= PWDATA[15:0];
      end
   end

   // flags: all four replaced together by a rotate; carry also by carry ops
   always @(posedge CLK) begin
      if (RESET) begin
         ERROR_FLAG <= 1'b0;
         EQUALS_FLAG <= 1'b0;
         CARRY_FLAG <= 1'b0;
         NEGATIVE_FLAG <= 1'b0;
      end else if (run_now) begin
         // all four from one rotator result, so no partial update is seen
         ERROR_FLAG <= rot_error;
         EQUALS_FLAG <= rot_equals;
         CARRY_FLAG <= rot_carry;
         NEGATIVE_FLAG <= rot_negative;
      end else if (carry_write) begin
         // held until the next rotate replaces it; only carry-inclusive rotates read it
         CARRY_FLAG <= next_carry_manual;
      end
   end

   // execution bookkeeping: done pulse, last scan outcome, run counter
   always @(posedge CLK) begin
      if (RESET) begin
         EXEC_DONE <= 1'b0;
         last_ran <= 1'b0;
         exec_count <= `RTC_RST_COUNT;
      end else begin
         EXEC_DONE <= run_now;
         // last_ran lets software tell a refused scan from an executed one
         if (scan_write) begin
            last_ran <= run_now;
         end
         if (run_now) begin
            // wraps silently; software only uses it to see progress
            exec_count <= exec_count + 16'h0001;
         end
      end
   end

endmodule

// file: rtc_unit_asserts.sv
// concurrent checks on the rotate unit's ports
`include "rtc_defines.vh"
module rtc_unit_asserts (
   // clock and reset
   input wire CLK,
   input wire RESET,
   // apb
   input wire PSEL,
   input wire PENABLE,
   input wire PWRITE,
   input wire [7:0] PADDR,
   input wire [31:0] PWDATA,
   input wire [31:0] PRDATA,
   input wire PREADY,
   input wire PSLVERR,
   // words and flags
   input wire [15:0] OPERAND_WORD_LO,
   input wire [15:0] OPERAND_WORD_HI,
   input wire ERROR_FLAG,
   input wire EQUALS_FLAG,
   input wire CARRY_FLAG,
   input wire NEGATIVE_FLAG,
   input wire EXEC_DONE
);
   timeunit 1ns;
   timeprecision 1ns;
   wire wr = PSEL && PENABLE && PREADY && PWRITE;
   wire scan_wr = wr && PADDR == `RTC_OFS_SCAN;
   reg [1:0] op_q;
   reg edge_q;
   reg prev_q;
   reg [15:0] lo_q;
   reg [15:0] hi_q;
   reg c_q;
   wire run = PWDATA[0] && !(edge_q && prev_q);
   // shadow of mode and old words, since the body is not visible here
   always @(posedge CLK) begin
      lo_q <= OPERAND_WORD_LO;
      hi_q <= OPERAND_WORD_HI;
      c_q <= CARRY_FLAG;
      if (RESET) begin
         op_q <= 2'h0;
         edge_q <= 1'b0;
         prev_q <= 1'b0;
      end else begin
         if (wr && PADDR == `RTC_OFS_CTRL) begin
            op_q <= PWDATA[1:0];
            edge_q <= PWDATA[2];
         end
         if (scan_wr)
            prev_q <= PWDATA[0];
      end
   end
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RESET);
   wait_state_a: assert property (PSEL && $rose(PENABLE) |-> !PREADY ##1 PREADY)
      else $error("wait state wrong");
   rotl_dbl_a: assert property (EXEC_DONE && op_q == 2'h0 |->
      {CARRY_FLAG, OPERAND_WORD_HI, OPERAND_WORD_LO} == {hi_q, lo_q, c_q}) else $error("dbl left");
   rotr_sgl_a: assert property (EXEC_DONE && op_q == 2'h1 |->
      {OPERAND_WORD_HI, OPERAND_WORD_LO, CARRY_FLAG} == {hi_q, c_q, lo_q}) else $error("sgl right");
   rotr_dbl_a: assert property (EXEC_DONE && op_q == 2'h2 |->
      {OPERAND_WORD_HI, OPERAND_WORD_LO, CARRY_FLAG} == {c_q, hi_q, lo_q}) else $error("dbl right");
   rotl_nc_a: assert property (EXEC_DONE && op_q == 2'h3 |->
      {OPERAND_WORD_HI, CARRY_FLAG, OPERAND_WORD_LO} == {hi_q, lo_q[15], lo_q[14:0], lo_q[15]})
      else $error("left no carry");
   err_eq_a: assert property (EXEC_DONE |-> !ERROR_FLAG && EQUALS_FLAG ==
      (op_q[0] ? OPERAND_WORD_LO == 16'h0000 : {OPERAND_WORD_HI, OPERAND_WORD_LO} == 32'h0))
      else $error("error or equals");
   neg_flag_a: assert property (EXEC_DONE |->
      NEGATIVE_FLAG == (op_q[0] ? OPERAND_WORD_LO[15] : OPERAND_WORD_HI[15])) else $error("negative");
   run_cond_a: assert property (scan_wr |=> EXEC_DONE == $past(run))
      else $error("execution condition");
   words_hold_a: assert property (!wr |=> $stable(OPERAND_WORD_LO) && $stable(OPERAND_WORD_HI)
      && $stable(CARRY_FLAG)) else $error("words moved");
   slave_err_a: assert property (PREADY && PADDR[1:0] == 2'h0 |->
      PSLVERR == (PADDR > 8'h18 || PWRITE && (PADDR == 8'h10 || PADDR == 8'h18))) else $error("slverr");
   cover property (EXEC_DONE && op_q == 2'h2);
   cover property (scan_wr && edge_q && prev_q && PWDATA[0]);
   cover property (PSLVERR);
endmodule

// file: rtc_seq_model.sv
// sequencer model: issues register and scan requests over apb
module rtc_seq_model (
   // clock
   input wire clk,
   // request
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [7:0] paddr,
   output logic [31:0] pwdata,
   // answer
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h00000000;
   end
   // only rising-edge or level scans exist; no refresh form is issued
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      pwdata <= ~d; // released data must not look valid
   endtask
endmodule

// file: rotate_through_carry_unit_tb.sv
// self-checking bench for the rotate unit
`include "rtc_defines.vh"
module rotate_through_carry_unit_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic CLK = 1'b0;
   logic RESET = 1'b1;
   wire PSEL, PENABLE, PWRITE, PREADY, PSLVERR, EXEC_DONE;
   wire [7:0] PADDR;
   wire [31:0] PWDATA, PRDATA;
   wire [15:0] OPERAND_WORD_LO, OPERAND_WORD_HI;
   wire ERROR_FLAG, EQUALS_FLAG, CARRY_FLAG, NEGATIVE_FLAG;
   int err_total = 0;
   int samples_checked = 0;
   logic [31:0] rd;
   logic se;
   logic [1:0] op;
   logic cin, xc;
   logic [15:0] hi, lo, xhi, xlo;
   logic [31:0] xflags;
   // op, carry in, hi, lo, then carry, hi, lo after one rotate
   logic [67:0] rows [8] = '{{2'h0, 1'h1, 16'h8000, 16'h8001, 1'h1, 16'h0001, 16'h0003},
      {2'h0, 1'h0, 16'h8000, 16'h0000, 1'h1, 16'h0000, 16'h0000},
      {2'h1, 1'h1, 16'h1234, 16'h0002, 1'h0, 16'h1234, 16'h8001},
      {2'h1, 1'h0, 16'hFFFF, 16'h0001, 1'h1, 16'hFFFF, 16'h0000},
      {2'h2, 1'h1, 16'h0001, 16'h0000, 1'h0, 16'h8000, 16'h8000},
      {2'h2, 1'h0, 16'h0000, 16'h0001, 1'h1, 16'h0000, 16'h0000},
      {2'h3, 1'h1, 16'hABCD, 16'h4000, 1'h0, 16'hABCD, 16'h8000},
      {2'h3, 1'h0, 16'h0000, 16'h8000, 1'h1, 16'h0000, 16'h0001}};
   // control, condition, then low word after the scan
   logic [19:0] steps [7] = '{20'hF0001, 20'hF0001, 20'hE0001, 20'hF0002, 20'h70004, 20'h70008, 20'h60008};
   rtc_unit dut (.CLK, .RESET, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR,
      .OPERAND_WORD_LO, .OPERAND_WORD_HI, .ERROR_FLAG, .EQUALS_FLAG, .CARRY_FLAG, .NEGATIVE_FLAG, .EXEC_DONE);
   rtc_seq_model seq (.clk(CLK), .psel(PSEL), .penable(PENABLE), .pwrite(PWRITE), .paddr(PADDR),
      .pwdata(PWDATA), .prdata(PRDATA), .pready(PREADY), .pslverr(PSLVERR));
   always #25 CLK = ~CLK;
   task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      seq.xfer(1'b1, a, d, rd, se);
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // watchdog, several times the expected run length
   initial begin
      repeat (4000) @(posedge CLK);
      err_total++;
      complete_run;
   end
   initial begin
      repeat (6) @(posedge CLK);
      RESET <= 1'b0;
      @(negedge CLK);
      check("reset", {OPERAND_WORD_HI, OPERAND_WORD_LO, ERROR_FLAG, EQUALS_FLAG, CARRY_FLAG, NEGATIVE_FLAG}, 0);
      $display("reset test done");
      // carry is loaded by a carry op so it enters the ring of the carry-inclusive rotates
      foreach (rows[i]) begin
         {op, cin, hi, lo, xc, xhi, xlo} = rows[i];
         wr(`RTC_OFS_CTRL, {30'h0, op});
         wr(`RTC_OFS_WORD_LO, {16'h0, lo});
         wr(`RTC_OFS_WORD_HI, {16'h0, hi});
         wr(`RTC_OFS_CARRY_OP, cin ? 32'h1 : 32'h2);
         wr(`RTC_OFS_SCAN, 32'h1);
         @(negedge CLK);
         check("words", {OPERAND_WORD_HI, OPERAND_WORD_LO}, {xhi, xlo});
         check("carry", CARRY_FLAG, xc);
         check("done", EXEC_DONE, 1'b1);
         seq.xfer(1'b0, `RTC_OFS_FLAGS, 32'h0, rd, se);
         xflags = {28'h0, op[0] ? xlo[15] : xhi[15], xc, op[0] ? xlo == 0 : {xhi, xlo} == 0, 1'b0};
         check("flags", rd, xflags);
         $display("row %0d done", i);
      end
      // held condition in edge mode starts refused, as the last scan was true
      wr(`RTC_OFS_WORD_LO, 32'h1);
      xlo = 16'h0001;
      foreach (steps[i]) begin
         wr(`RTC_OFS_CTRL, {29'h0, steps[i][19:17]});
         wr(`RTC_OFS_SCAN, {31'h0, steps[i][16]});
         @(negedge CLK);
         check("scan word", OPERAND_WORD_LO, steps[i][15:0]);
         // every executed left rotate of a word that is neither all zeros nor all ones changes it
         check("scan done", EXEC_DONE, steps[i][15:0] != xlo);
         xlo = steps[i][15:0];
      end
      $display("scan test done");
      wr(`RTC_OFS_FLAGS, 32'hF);
      check("flags write", se, 1'b1);
      seq.xfer(1'b0, 8'h1C, 32'h0, rd, se);
      check("unmapped", {se, rd}, {1'b1, 32'h0});
      $display("refusal test done");
      // reset in mid-run brings words, flags and control back to rest
      @(posedge CLK);
      RESET <= 1'b1;
      repeat (2) @(posedge CLK);
      RESET <= 1'b0;
      @(negedge CLK);
      check("mid reset", {OPERAND_WORD_HI, OPERAND_WORD_LO, ERROR_FLAG, EQUALS_FLAG, CARRY_FLAG, NEGATIVE_FLAG,
         EXEC_DONE}, 0);
      seq.xfer(1'b0, `RTC_OFS_CTRL, 32'h0, rd, se);
      check("mid reset ctrl", rd, 32'h0);
      $display("mid reset test done");
      complete_run;
   end
endmodule
bind rtc_unit rtc_unit_asserts chk (.CLK, .RESET, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA,
   .PREADY, .PSLVERR, .OPERAND_WORD_LO, .OPERAND_WORD_HI, .ERROR_FLAG, .EQUALS_FLAG, .CARRY_FLAG,
   .NEGATIVE_FLAG, .EXEC_DONE);
